// >>> src/rpc_pkg.sv
// How it works
// - Unused upper bits of both registers read as zero and ignore writes.
// - The low byte tallies receive errors seen with carrier and bad symbols.
// - One carrier event adds at most one, however many errors it holds.
// - A carrier event that saw a collision adds nothing.
// - The tally sticks at all ones and never wraps.
// - Config bit 10 puts the transmitter in true quiet mode; clear is normal.
// - Config bit 9 forces the signal to count as present.
// - Bit 8 set: link rises on signal and lock, holds while signal stays.
// - Bit 8 clear: link rises on signal and lock, drops if either is lost.
// - Bit 7 picks a 2 ms lock timeout, otherwise 722 us.
// - Config bit 5 forces a good 100 Mb/s link.
// - Config bit 2 bypasses the line coding stage in both directions.
package rpc_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0]  RPC_IDX_ERR   = 8'h15;
    localparam logic [7:0]  RPC_IDX_CFG   = 8'h16;
    // config field positions
    localparam int          RPC_B_FREECLK = 11;
    localparam int          RPC_B_QUIET   = 10;
    localparam int          RPC_B_FORCESD = 9;
    localparam int          RPC_B_HOLD    = 8;
    localparam int          RPC_B_LONGTMO = 7;
    localparam int          RPC_B_FORCEOK = 5;
    localparam int          RPC_B_BYPASS  = 2;
    localparam logic [15:0] RPC_CFG_WMASK = 16'h0FA4;
    localparam logic [15:0] RPC_CFG_RST   = 16'h0100;
    localparam logic [7:0]  RPC_CNT_RST   = 8'h00;
    localparam logic [7:0]  RPC_CNT_MAX   = 8'hFF;
    // lock timeouts
    localparam int          RPC_CLK_NS    = 10;
    localparam int          RPC_SHORT_US  = 722;
    localparam int          RPC_LONG_MS   = 2;
    localparam int          RPC_SHORT_CYC = RPC_SHORT_US * 1000 / RPC_CLK_NS;
    localparam int          RPC_LONG_CYC  = RPC_LONG_MS * 1000000 / RPC_CLK_NS;
    localparam int          RPC_TMO_W     = 18;
    typedef logic [7:0]           rpc_cnt_t;
    typedef logic [RPC_TMO_W-1:0] rpc_tmo_t;
endpackage

// >>> src/rpc_err_tally.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_err_tally (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        carrier_i,
    input  wire logic        rx_err_i,
    input  wire logic        collision_i,
    input  wire logic        clear_i,
    output rpc_pkg::rpc_cnt_t count_o
);
    import rpc_pkg::*;

    typedef enum logic {TAL_IDLE, TAL_EVENT} rpc_tal_t;

    rpc_tal_t state;
    logic     seen_err;
    logic     seen_col;
    logic     bump;

    // carrier event tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= TAL_IDLE;
        end else begin
            case (state)
                TAL_IDLE:  if (carrier_i) state <= TAL_EVENT;
                TAL_EVENT: if (!carrier_i) state <= TAL_IDLE;
                default:   state <= TAL_IDLE;
            endcase
        end
    end

    // flags gathered over one event, errors only count under carrier
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_err <= 1'b0;
            seen_col <= 1'b0;
        end else if (carrier_i && state == TAL_IDLE) begin
            seen_err <= rx_err_i;
            seen_col <= collision_i;
        end else if (carrier_i) begin
            seen_err <= seen_err | rx_err_i;
            seen_col <= seen_col | collision_i;
        end
    end

    // decided at carrier end so a late collision still vetoes
    assign bump = state == TAL_EVENT && !carrier_i
                  && seen_err && !seen_col;

    // a clear in the same cycle as a bump restarts the count at one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= RPC_CNT_RST;
        end else if (bump) begin
            if (clear_i) count_o <= 8'h01;
            else if (count_o != RPC_CNT_MAX) count_o <= count_o + 8'h01;
        end else if (clear_i) begin
            count_o <= RPC_CNT_RST;
        end
    end

    property p_sat;
        @(posedge clk_i) disable iff (rst_i)
        count_o == RPC_CNT_MAX && !clear_i |=> count_o == RPC_CNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("tally wrapped");

    property p_col;
        @(posedge clk_i) disable iff (rst_i)
        state == TAL_EVENT && seen_col && !carrier_i && !clear_i
        |=> count_o == $past(count_o);
    endproperty
    a_col: assert property (p_col) else $error("collision counted");

    property p_once;
        @(posedge clk_i) disable iff (rst_i)
        carrier_i && state == TAL_EVENT && !clear_i
        |=> count_o == $past(count_o);
    endproperty
    a_once: assert property (p_once) else $error("mid event bump");

    property p_count;
        @(posedge clk_i) disable iff (rst_i)
        bump && !clear_i && count_o != RPC_CNT_MAX
        |=> count_o == $past(count_o) + 8'h01;
    endproperty
    a_count: assert property (p_count) else $error("error missed");
endmodule
`default_nettype wire

// >>> src/rpc_link_mon.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_link_mon #(
    parameter int SHORT_CYC = rpc_pkg::RPC_SHORT_CYC,
    parameter int LONG_CYC  = rpc_pkg::RPC_LONG_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic signal_i,
    input  wire logic sync_i,
    input  wire logic force_sd_i,
    input  wire logic hold_i,
    input  wire logic long_tmo_i,
    input  wire logic force_ok_i,
    output logic      sig_o,
    output logic      lock_o,
    output logic      link_o
);
    import rpc_pkg::*;

    typedef enum logic {LNK_DOWN, LNK_UP} rpc_lnk_t;

    localparam rpc_tmo_t SHORT_LIM = rpc_tmo_t'(SHORT_CYC - 1);
    localparam rpc_tmo_t LONG_LIM  = rpc_tmo_t'(LONG_CYC - 1);

    rpc_lnk_t state;
    rpc_tmo_t timer;
    rpc_tmo_t limit;

    assign sig_o = signal_i | force_sd_i;
    assign limit = long_tmo_i ? LONG_LIM : SHORT_LIM;

    // lock kept alive by sync, lost after a quiet timeout
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_o <= 1'b0;
            timer  <= '0;
        end else if (sync_i) begin
            lock_o <= 1'b1;
            timer  <= '0;
        end else if (lock_o) begin
            if (timer >= limit) lock_o <= 1'b0;
            else timer <= timer + 1'b1;
        end
    end

    // link state under the selected hold policy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= LNK_DOWN;
        end else begin
            case (state)
                LNK_DOWN: if (sig_o && lock_o) state <= LNK_UP;
                LNK_UP: begin
                    if (!sig_o || (!hold_i && !lock_o)) state <= LNK_DOWN;
                end
                default: state <= LNK_DOWN;
            endcase
        end
    end

    assign link_o = force_ok_i | (state == LNK_UP);

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        state == LNK_UP && hold_i && sig_o |=> state == LNK_UP;
    endproperty
    a_hold: assert property (p_hold) else $error("link dropped");

    property p_strict;
        @(posedge clk_i) disable iff (rst_i)
        state == LNK_UP && !hold_i && !lock_o |=> state == LNK_DOWN;
    endproperty
    a_strict: assert property (p_strict) else $error("link kept");
endmodule
`default_nettype wire

// >>> src/rpc_top.sv
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rpc_top #(
    parameter int LOCK_SHORT_CYC = rpc_pkg::RPC_SHORT_CYC,
    parameter int LOCK_LONG_CYC  = rpc_pkg::RPC_LONG_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    // line side pins, asynchronous
    input  wire logic        crs_pin_i,
    input  wire logic        rx_er_pin_i,
    input  wire logic        col_pin_i,
    input  wire logic        sig_det_pin_i,
    input  wire logic        desc_sync_pin_i,
    input  wire logic        rx_line_pin_i,
    // transmit code bit from local logic
    input  wire logic        tx_code_i,
    output logic             tx_line_o,
    output logic             rx_code_o,
    output logic             link_good_o,
    output logic             signal_present_o,
    output logic             desc_lock_o,
    output logic             quiet_transmit_enable_o,
    output logic             rx_clk_free_o
);
    import rpc_pkg::*;

    localparam int NPIN = 6;

    // pin bit order inside the synchroniser
    localparam int P_CRS  = 0;
    localparam int P_RXER = 1;
    localparam int P_COL  = 2;
    localparam int P_SIG  = 3;
    localparam int P_SYNC = 4;
    localparam int P_LINE = 5;

    logic [NPIN-1:0] pin_raw;
    wire  [NPIN-1:0] pin_s;
    logic [15:0]     cfg;
    rpc_cnt_t        tally;
    logic            req;
    logic            start;
    logic            wr_cfg;
    logic            rd_err;
    logic [15:0]     next_cfg;
    logic [15:0]     rd_word;
    logic            tx_nrzi;
    logic            rx_prev;
    logic            sig_eff;

    // register hit for one index, word aligned only
    function automatic logic reg_hit(input logic [7:0] adr,
                                     input logic [7:0] idx);
        reg_hit = adr[7:2] == idx[5:0] && adr[1:0] == 2'b00;
    endfunction

    assign pin_raw = {rx_line_pin_i, desc_sync_pin_i, sig_det_pin_i,
                      col_pin_i, rx_er_pin_i, crs_pin_i};

    // two flops per pin, first stage feeds only the second
    // local flops per lane so no vector has several clocked writers
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= pin_raw[gi];
                    sync_q <= meta_q;
                end
            end
            assign pin_s[gi] = sync_q;
        end
    endgenerate

    // bus side: one wait state, ack held for a single cycle
    assign req    = cyc_i && stb_i;
    assign start  = req && !ack_o;
    assign wr_cfg = start && we_i && reg_hit(adr_i, RPC_IDX_CFG);
    assign rd_err = start && !we_i && reg_hit(adr_i, RPC_IDX_ERR);

    always_ff @(posedge clk_i) begin
        if (rst_i) ack_o <= 1'b0;
        else ack_o <= start;
    end

    // byte lanes 0 and 1 carry the 16 bit register
    always_comb begin
        next_cfg = cfg;
        if (sel_i[0]) next_cfg[7:0] = dat_i[7:0];
        if (sel_i[1]) next_cfg[15:8] = dat_i[15:8];
        next_cfg = next_cfg & RPC_CFG_WMASK;
    end

    // configuration storage
    always_ff @(posedge clk_i) begin
        if (rst_i) cfg <= RPC_CFG_RST;
        else if (wr_cfg) cfg <= next_cfg;
    end

    // read mux, unmapped and reserved bits return zero
    always_comb begin
        rd_word = 16'h0000;
        if (reg_hit(adr_i, RPC_IDX_ERR)) rd_word = {8'h00, tally};
        else if (reg_hit(adr_i, RPC_IDX_CFG)) rd_word = cfg;
    end

    // data captured with the old tally before the clear lands
    always_ff @(posedge clk_i) begin
        if (rst_i) dat_o <= 32'h0000_0000;
        else if (start && !we_i) dat_o <= {16'h0000, rd_word};
    end

    rpc_err_tally u_tally (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .carrier_i   (pin_s[P_CRS]),
        .rx_err_i    (pin_s[P_RXER]),
        .collision_i (pin_s[P_COL]),
        .clear_i     (rd_err),
        .count_o     (tally)
    );

    rpc_link_mon #(
        .SHORT_CYC (LOCK_SHORT_CYC),
        .LONG_CYC  (LOCK_LONG_CYC)
    ) u_link (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .signal_i   (pin_s[P_SIG]),
        .sync_i     (pin_s[P_SYNC]),
        .force_sd_i (cfg[RPC_B_FORCESD]),
        .hold_i     (cfg[RPC_B_HOLD]),
        .long_tmo_i (cfg[RPC_B_LONGTMO]),
        .force_ok_i (cfg[RPC_B_FORCEOK]),
        .sig_o      (sig_eff),
        .lock_o     (desc_lock_o),
        .link_o     (link_good_o)
    );

    assign signal_present_o        = sig_eff;
    assign quiet_transmit_enable_o = cfg[RPC_B_QUIET];
    // stored only, no receive clock logic behind it
    assign rx_clk_free_o           = cfg[RPC_B_FREECLK];

    // transmit line coding: a one toggles the line
    always_ff @(posedge clk_i) begin
        if (rst_i) tx_nrzi <= 1'b0;
        else if (tx_code_i) tx_nrzi <= !tx_nrzi;
    end

    // quiet keeps the line still, bypass sends code bits raw
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_line_o <= 1'b0;
        end else if (cfg[RPC_B_QUIET]) begin
            tx_line_o <= 1'b0;
        end else if (cfg[RPC_B_BYPASS]) begin
            tx_line_o <= tx_code_i;
        end else begin
            tx_line_o <= tx_nrzi ^ tx_code_i;
        end
    end

    // receive decode: a line change is a one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_prev   <= 1'b0;
            rx_code_o <= 1'b0;
        end else begin
            rx_prev <= pin_s[P_LINE];
            if (cfg[RPC_B_BYPASS]) rx_code_o <= pin_s[P_LINE];
            else rx_code_o <= pin_s[P_LINE] ^ rx_prev;
        end
    end

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");

    property p_err_upper;
        @(posedge clk_i) disable iff (rst_i)
        start && !we_i && reg_hit(adr_i, RPC_IDX_ERR)
        |=> ack_o && dat_o[31:8] == 24'h000000;
    endproperty
    a_err_upper: assert property (p_err_upper) else $error("upper set");

    property p_cfg_rsv;
        @(posedge clk_i) disable iff (rst_i)
        (cfg & ~RPC_CFG_WMASK) == 16'h0000;
    endproperty
    a_cfg_rsv: assert property (p_cfg_rsv) else $error("reserved kept");

    property p_rdclr;
        @(posedge clk_i) disable iff (rst_i)
        rd_err && !u_tally.bump |=> tally == RPC_CNT_RST;
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("no read clear");

    property p_rdval;
        @(posedge clk_i) disable iff (rst_i)
        rd_err |=> dat_o[7:0] == $past(tally);
    endproperty
    a_rdval: assert property (p_rdval) else $error("stale tally read");

    property p_quiet;
        @(posedge clk_i) disable iff (rst_i)
        cfg[RPC_B_QUIET] |=> !tx_line_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("quiet line moved");

    property p_bypass;
        @(posedge clk_i) disable iff (rst_i)
        cfg[RPC_B_BYPASS] && !cfg[RPC_B_QUIET]
        |=> tx_line_o == $past(tx_code_i);
    endproperty
    a_bypass: assert property (p_bypass) else $error("coding applied");

    property p_force_ok;
        @(posedge clk_i) disable iff (rst_i)
        cfg[RPC_B_FORCEOK] |-> link_good_o;
    endproperty
    a_force_ok: assert property (p_force_ok) else $error("link not forced");

    property p_force_sd;
        @(posedge clk_i) disable iff (rst_i)
        cfg[RPC_B_FORCESD] |-> signal_present_o;
    endproperty
    a_force_sd: assert property (p_force_sd) else $error("sd not forced");

    property p_timeout;
        @(posedge clk_i) disable iff (rst_i)
        desc_lock_o && !pin_s[P_SYNC] && u_link.timer >= u_link.limit
        |=> !desc_lock_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("lock outlived");

    property p_wr_mask;
        @(posedge clk_i) disable iff (rst_i)
        wr_cfg && sel_i[1:0] == 2'b11
        |=> cfg == ($past(dat_i[15:0]) & RPC_CFG_WMASK);
    endproperty
    a_wr_mask: assert property (p_wr_mask) else $error("write lost");
endmodule
`default_nettype wire

// >>> dv/rpc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// line side of the receiver: carrier events, signal level, descrambler sync
module rpc_line_model (
    input  wire logic clk_i,
    output logic      crs_o,
    output logic      rx_er_o,
    output logic      col_o,
    output logic      sig_o,
    output logic      sync_o
);
    // idle line: every pin pulled low
    initial begin
        crs_o   = 1'b0;
        rx_er_o = 1'b0;
        col_o   = 1'b0;
        sig_o   = 1'b0;
        sync_o  = 1'b0;
    end

    // one carrier event, error pulses spaced apart, collision optional
    task automatic frame(input int n_err, input bit col);
        int i;
        @(posedge clk_i);
        crs_o <= 1'b1;
        col_o <= col;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_i);
            rx_er_o <= (i % 2 == 1) && (i / 2 < n_err);
        end
        @(posedge clk_i);
        crs_o   <= 1'b0;
        rx_er_o <= 1'b0;
        col_o   <= 1'b0;
        // gap so the synchroniser sees a clear end of event
        repeat (5) @(posedge clk_i);
    endtask

    // single cycle sync seen by the descrambler
    task automatic sync_pulse();
        @(posedge clk_i);
        sync_o <= 1'b1;
        @(posedge clk_i);
        sync_o <= 1'b0;
    endtask

    task automatic set_sig(input bit v);
        @(posedge clk_i);
        sig_o <= v;
    endtask
endmodule
`default_nettype wire

// >>> dv/rx_error_count_pcs_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rx_error_count_pcs_config_tb;
    import rpc_pkg::*;
    // short lock timeouts keep the run brief
    localparam int         SHORT = 20;
    localparam int         LONG  = 50;
    localparam logic [7:0] A_ERR = {RPC_IDX_ERR[5:0], 2'b00};
    localparam logic [7:0] A_CFG = {RPC_IDX_CFG[5:0], 2'b00};

    logic        clk_i, rst_i, we_i, cyc_i, stb_i, tx_code_i, ack_o;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [3:0]  sel_i;
    logic        crs, rxer, col, sig, sync, s;
    logic        tx_line_o, rx_code_o, link_good_o, signal_present_o;
    logic        desc_lock_o, quiet_o, free_o;
    int          n_fail, num_checks, k;

    rpc_line_model line (
        .clk_i  (clk_i),
        .crs_o  (crs),
        .rx_er_o(rxer),
        .col_o  (col),
        .sig_o  (sig),
        .sync_o (sync)
    );

    rpc_top #(.LOCK_SHORT_CYC(SHORT), .LOCK_LONG_CYC(LONG)) dut (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .adr_i                  (adr_i),
        .dat_i                  (dat_i),
        .dat_o                  (dat_o),
        .we_i                   (we_i),
        .sel_i                  (sel_i),
        .cyc_i                  (cyc_i),
        .stb_i                  (stb_i),
        .ack_o                  (ack_o),
        .crs_pin_i              (crs),
        .rx_er_pin_i            (rxer),
        .col_pin_i              (col),
        .sig_det_pin_i          (sig),
        .desc_sync_pin_i        (sync),
        .rx_line_pin_i          (tx_line_o),
        .tx_code_i              (tx_code_i),
        .tx_line_o              (tx_line_o),
        .rx_code_o              (rx_code_o),
        .link_good_o            (link_good_o),
        .signal_present_o       (signal_present_o),
        .desc_lock_o            (desc_lock_o),
        .quiet_transmit_enable_o(quiet_o),
        .rx_clk_free_o          (free_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'h3;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        if (n == 20) begin
            n_fail++;
            end_of_test();
        end
    endtask

    initial begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
        adr_i = 8'h00; dat_i = 32'h0; sel_i = 4'h0; tx_code_i = 1'b0;
        n_fail = 0; num_checks = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, A_CFG, 32'h0, rd); check(rd, 32'h0000_0100);
        wb(1'b0, A_ERR, 32'h0, rd); check(rd, 32'h0);
        // all ones, reserved bits included on purpose
        wb(1'b1, A_CFG, 32'hFFFF_FFFF, rd);
        wb(1'b0, A_CFG, 32'h0, rd); check(rd, {16'h0, RPC_CFG_WMASK});
        check({31'h0, quiet_o}, 32'h1);
        check({31'h0, tx_line_o}, 32'h0);
        check({31'h0, signal_present_o}, 32'h1);
        check({31'h0, link_good_o}, 32'h1);
        check({31'h0, free_o}, 32'h1);
        // bypass: a steady one passes straight through
        wb(1'b1, A_CFG, 32'h0000_0004, rd);
        tx_code_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        s = tx_line_o;
        @(posedge clk_i);
        check({30'h0, s, tx_line_o}, 32'h3);
        // line looped back: raw level seen on the receive side
        check({31'h0, rx_code_o}, 32'h1);
        check({31'h0, signal_present_o}, 32'h0);
        check({31'h0, link_good_o}, 32'h0);
        // coded: a steady one toggles the line each cycle
        wb(1'b1, A_CFG, 32'h0, rd);
        repeat (4) @(posedge clk_i);
        s = tx_line_o;
        @(posedge clk_i);
        check({31'h0, tx_line_o}, {31'h0, ~s});
        // toggling line decodes back to ones
        check({31'h0, rx_code_o}, 32'h1);
        tx_code_i <= 1'b0;
        // several errors in one event count once; writes to tally dropped
        line.frame(3, 1'b0);
        wb(1'b1, A_ERR, 32'h0000_FFFF, rd);
        wb(1'b0, A_ERR, 32'h0, rd); check(rd, 32'h1);
        wb(1'b0, A_ERR, 32'h0, rd); check(rd, 32'h0);
        line.frame(2, 1'b1);
        line.frame(0, 1'b0);
        wb(1'b0, A_ERR, 32'h0, rd); check(rd, 32'h0);
        // saturation at all ones
        for (k = 0; k < 258; k++)
            line.frame(1, 1'b0);
        wb(1'b0, A_ERR, 32'h0, rd); check(rd, {24'h0, RPC_CNT_MAX});
        wb(1'b0, A_ERR, 32'h0, rd); check(rd, 32'h0);
        // strict policy: lock loss drops the link
        line.set_sig(1'b1);
        line.sync_pulse();
        repeat (6) @(posedge clk_i);
        check({31'h0, link_good_o}, 32'h1);
        repeat (40) @(posedge clk_i);
        check({30'h0, desc_lock_o, link_good_o}, 32'h0);
        // hold policy: link survives lock loss, not signal loss
        wb(1'b1, A_CFG, 32'h0000_0100, rd);
        line.sync_pulse();
        repeat (6) @(posedge clk_i);
        check({31'h0, link_good_o}, 32'h1);
        repeat (40) @(posedge clk_i);
        check({30'h0, desc_lock_o, link_good_o}, 32'h1);
        line.set_sig(1'b0);
        repeat (6) @(posedge clk_i);
        check({31'h0, link_good_o}, 32'h0);
        // long timeout keeps lock past the short limit
        wb(1'b1, A_CFG, 32'h0000_0180, rd);
        line.sync_pulse();
        repeat (35) @(posedge clk_i);
        check({31'h0, desc_lock_o}, 32'h1);
        repeat (30) @(posedge clk_i);
        check({31'h0, desc_lock_o}, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
